// ---- fms_serial_port.sv ----
// four-mode serial port with APB register access
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "fms_defines.svh"
module fms_serial_port (
  input wire logic clk_i,               // 10 MHz system clock
  input wire logic nrst_i,              // async reset, active low
  input wire logic psel_i,              // APB select
  input wire logic penable_i,           // APB enable
  input wire logic pwrite_i,            // APB write
  input wire logic [11:0] paddr_i,      // APB byte address
  input wire logic [31:0] pwdata_i,     // APB write data
  output logic [31:0] prdata_o,         // APB read data
  output logic pready_o,                // APB ready
  output logic pslverr_o,               // APB error on unmapped address
  input wire logic serial_in_i,         // serial_in_pin level
  output logic serial_data_o,           // serial_in_pin drive value, mode 0 tx
  output logic serial_data_oe_n_o,      // serial_in_pin enable, low drives
  output logic serial_out_o,            // serial_out_pin: tx line or mode 0 clock
  output logic irq_o                    // port interrupt request
);
  logic [7:0] ctrl_high;
  logic [7:0] ctrl_low;
  logic [7:0] divisor;
  logic [7:0] rx_buf;
  fms_pkg::fms_mode_type mode;
  logic mode0;
  logic nine_bit;
  fms_baud_if baud ();
  logic tick;

  // apb decode
  logic hit_ch;
  logic hit_cl;
  logic hit_data;
  logic hit_div;
  logic mapped;
  logic access;
  logic wr_ch;
  logic wr_cl;
  logic wr_data;
  logic wr_div;

  // transmitter
  fms_pkg::fms_tx_state_type tx_state;
  logic [7:0] tx_shift;
  logic tx_ninth;
  logic [3:0] tx_sub;
  logic [2:0] tx_cnt;
  logic tx_bit_end;
  logic tx_set_pend;
  logic tx_line;

  // receiver
  fms_pkg::fms_rx_state_type rx_state;
  logic [7:0] rx_shift;
  logic [3:0] rx_sub;
  logic [2:0] rx_cnt;
  logic rx_bit_end;
  logic rx_done;
  logic rx_accept;
  logic rx_ninth_load;
  logic [7:0] rx_byte;
  logic rx_start0;
  logic rx_start_async;
  logic sclk_active;
  logic [3:0] sclk_sub;
  logic rx_in_prev;

  assign mode = fms_pkg::fms_mode_type'(ctrl_high[`FMS_CH_MODE_MSB:`FMS_CH_MODE_LSB]);
  assign mode0 = mode == fms_pkg::fms_mode_shift;
  assign nine_bit = mode == fms_pkg::fms_mode_9fix || mode == fms_pkg::fms_mode_9var;

  fms_baud_gen u_baud (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .bus(baud.gen)
  );
  assign baud.divisor = divisor;
  assign baud.clk_sel = ctrl_low[`FMS_CL_CLK_MSB:`FMS_CL_CLK_LSB];
  assign baud.fixed_rate = mode == fms_pkg::fms_mode_9fix;
  assign tick = baud.tick16;

  // zero wait states; unmapped access answers with an error
  assign hit_ch = paddr_i == {2'h0, `FMS_IDX_CTRL_HIGH, 2'h0};
  assign hit_cl = paddr_i == {2'h0, `FMS_IDX_CTRL_LOW, 2'h0};
  assign hit_data = paddr_i == {2'h0, `FMS_IDX_DATA, 2'h0};
  assign hit_div = paddr_i == {2'h0, `FMS_IDX_DIVISOR, 2'h0};
  assign mapped = hit_ch | hit_cl | hit_data | hit_div;
  assign access = psel_i & penable_i;
  assign pready_o = 1'b1;
  assign pslverr_o = access & ~mapped;
  assign wr_ch = access & pwrite_i & hit_ch;
  assign wr_cl = access & pwrite_i & hit_cl;
  assign wr_data = access & pwrite_i & hit_data;
  assign wr_div = access & pwrite_i & hit_div;

  // read data captured in the setup cycle
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      prdata_o <= 32'h0000_0000;
    else if (psel_i && !penable_i && !pwrite_i)
    begin
      if (hit_ch)
        prdata_o <= {24'h00_0000, ctrl_high};
      else if (hit_cl)
        prdata_o <= {24'h00_0000, ctrl_low};
      else if (hit_data)
        prdata_o <= {24'h00_0000, rx_buf};
      else if (hit_div)
        prdata_o <= {24'h00_0000, divisor};
      else
        prdata_o <= 32'h0000_0000;
    end
  end

  // hardware sets win over a software clear in the same cycle
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ctrl_high <= `FMS_CTRL_HIGH_RST;
    else
    begin
      if (wr_ch)
        ctrl_high <= pwdata_i[7:0];
      if (rx_accept)
        ctrl_high[`FMS_CH_RIP] <= 1'b1;
      if (rx_ninth_load)
        ctrl_high[`FMS_CH_RX_NINTH] <= serial_in_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ctrl_low <= `FMS_CTRL_LOW_RST;
    else
    begin
      if (wr_cl)
        ctrl_low <= pwdata_i[7:0];
      if (tx_set_pend)
        ctrl_low[`FMS_CL_TIP] <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      divisor <= `FMS_DIVISOR_RST;
    else if (wr_div)
      divisor <= pwdata_i[7:0];
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      irq_o <= 1'b0;
    else
      irq_o <= (ctrl_high[`FMS_CH_RIP] & ctrl_high[`FMS_CH_RIE])
        | (ctrl_low[`FMS_CL_TIP] & ctrl_low[`FMS_CL_TIE]);
  end

  // transmitter: sixteen ticks per bit
  assign tx_bit_end = tick && tx_sub == `FMS_SUB_LAST;
  assign tx_set_pend = tx_bit_end && ((tx_state == fms_pkg::fms_tx_data && tx_cnt == `FMS_LAST_DATA_BIT
    && !nine_bit) || tx_state == fms_pkg::fms_tx_ninth);

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tx_state <= fms_pkg::fms_tx_idle;
      tx_shift <= 8'h00;
      tx_ninth <= 1'b0;
      tx_sub <= 4'h0;
      tx_cnt <= 3'h0;
    end
    else if (wr_data)
    begin
      tx_shift <= pwdata_i[7:0];
      tx_ninth <= ctrl_low[`FMS_CL_TXPAR] ? ^pwdata_i[7:0] : ctrl_high[`FMS_CH_TX_NINTH];
      tx_sub <= 4'h0;
      tx_cnt <= 3'h0;
      tx_state <= mode0 ? fms_pkg::fms_tx_data : fms_pkg::fms_tx_start;
    end
    else if (tick && tx_state != fms_pkg::fms_tx_idle)
    begin
      tx_sub <= tx_sub + 4'h1;
      if (tx_bit_end)
      begin
        case (tx_state)
          fms_pkg::fms_tx_start:
            tx_state <= fms_pkg::fms_tx_data;
          fms_pkg::fms_tx_data:
          begin
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_cnt <= tx_cnt + 3'h1;
            if (tx_cnt == `FMS_LAST_DATA_BIT)
            begin
              if (mode0)
                tx_state <= fms_pkg::fms_tx_idle;
              else if (nine_bit)
                tx_state <= fms_pkg::fms_tx_ninth;
              else
                tx_state <= fms_pkg::fms_tx_stop;
            end
          end
          fms_pkg::fms_tx_ninth:
            tx_state <= fms_pkg::fms_tx_stop;
          default:
            tx_state <= fms_pkg::fms_tx_idle;
        endcase
      end
    end
  end

  always_comb
  begin
    case (tx_state)
      fms_pkg::fms_tx_start: tx_line = 1'b0;
      fms_pkg::fms_tx_data: tx_line = tx_shift[0];
      fms_pkg::fms_tx_ninth: tx_line = tx_ninth;
      default: tx_line = 1'b1;
    endcase
  end

  // receiver
  assign rx_bit_end = tick && rx_sub == `FMS_SUB_LAST;
  assign rx_start0 = mode0 && ctrl_high[`FMS_CH_RX_EN] && !ctrl_high[`FMS_CH_RIP]
    && tx_state == fms_pkg::fms_tx_idle && !wr_data;
  assign rx_start_async = !mode0 && ctrl_high[`FMS_CH_RX_EN] && rx_in_prev && !serial_in_i;
  assign rx_done = rx_bit_end && ((rx_state == fms_pkg::fms_rx_data && rx_cnt == `FMS_LAST_DATA_BIT && mode0)
    || rx_state == fms_pkg::fms_rx_ninth || rx_state == fms_pkg::fms_rx_stop);
  assign rx_byte = mode0 ? {serial_in_i, rx_shift[7:1]} : rx_shift;
  assign rx_accept = rx_done && !(rx_state == fms_pkg::fms_rx_ninth && ctrl_high[`FMS_CH_FILTER]
    && !serial_in_i);
  assign rx_ninth_load = rx_accept && rx_state == fms_pkg::fms_rx_ninth;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rx_state <= fms_pkg::fms_rx_idle;
      rx_shift <= 8'h00;
      rx_sub <= 4'h0;
      rx_cnt <= 3'h0;
    end
    else
    begin
      case (rx_state)
        fms_pkg::fms_rx_idle:
        begin
          rx_sub <= 4'h0;
          rx_cnt <= 3'h0;
          if (rx_start0)
            rx_state <= fms_pkg::fms_rx_data;
          else if (rx_start_async)
            rx_state <= fms_pkg::fms_rx_start;
        end
        fms_pkg::fms_rx_start:
          if (tick)
          begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub == `FMS_SUB_MID)
            begin
              rx_sub <= 4'h0; // realign to mid-bit
              rx_state <= serial_in_i ? fms_pkg::fms_rx_idle : fms_pkg::fms_rx_data;
            end
          end
        fms_pkg::fms_rx_data:
          if (tick)
          begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub == `FMS_SUB_LAST)
            begin
              rx_shift <= {serial_in_i, rx_shift[7:1]};
              rx_cnt <= rx_cnt + 3'h1;
              if (rx_cnt == `FMS_LAST_DATA_BIT)
              begin
                if (mode0)
                  rx_state <= fms_pkg::fms_rx_idle;
                else if (nine_bit)
                  rx_state <= fms_pkg::fms_rx_ninth;
                else
                  rx_state <= fms_pkg::fms_rx_stop;
              end
            end
          end
        fms_pkg::fms_rx_ninth, fms_pkg::fms_rx_stop:
          if (tick)
          begin
            rx_sub <= rx_sub + 4'h1;
            if (rx_sub == `FMS_SUB_LAST)
              rx_state <= fms_pkg::fms_rx_idle; // stop bit not checked in 8-bit or 9-bit frames
          end
        default:
          rx_state <= fms_pkg::fms_rx_idle;
      endcase
    end
  end

  // start needs a falling edge, so a low ninth bit cannot restart the receiver
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rx_in_prev <= 1'b1;
    else
      rx_in_prev <= serial_in_i;
  end

  // newest byte overwrites an unread one
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rx_buf <= 8'h00;
    else if (rx_accept)
      rx_buf <= rx_byte;
  end

  // pins: mode 0 clock low in first half of each bit, idle high
  assign sclk_active = mode0 && (tx_state == fms_pkg::fms_tx_data || rx_state == fms_pkg::fms_rx_data);
  assign sclk_sub = tx_state == fms_pkg::fms_tx_data ? tx_sub : rx_sub;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      serial_out_o <= 1'b1;
      serial_data_o <= 1'b1;
      serial_data_oe_n_o <= 1'b1;
    end
    else
    begin
      serial_out_o <= mode0 ? !(sclk_active && !sclk_sub[3]) : tx_line;
      serial_data_o <= tx_shift[0];
      serial_data_oe_n_o <= !(mode0 && tx_state == fms_pkg::fms_tx_data);
    end
  end
endmodule

// ---- fms_defines.svh ----
// register indexes, field positions, reset values and bit timing of the serial port
`ifndef FMS_DEFINES_SVH
`define FMS_DEFINES_SVH
`define FMS_IDX_CTRL_HIGH 8'hf5
`define FMS_IDX_CTRL_LOW 8'hf6
`define FMS_IDX_DATA 8'hf7
`define FMS_IDX_DIVISOR 8'hf8
`define FMS_CTRL_HIGH_RST 8'h00
`define FMS_CTRL_LOW_RST 8'h00
`define FMS_DIVISOR_RST 8'h00
`define FMS_CH_MODE_MSB 7
`define FMS_CH_MODE_LSB 6
`define FMS_CH_FILTER 5
`define FMS_CH_RX_EN 4
`define FMS_CH_TX_NINTH 3
`define FMS_CH_RX_NINTH 2
`define FMS_CH_RIE 1
`define FMS_CH_RIP 0
`define FMS_CL_TXPAR 7
`define FMS_CL_RXPAR 6
`define FMS_CL_CLK_MSB 3
`define FMS_CL_CLK_LSB 2
`define FMS_CL_TIE 1
`define FMS_CL_TIP 0
`define FMS_SUB_MID 4'h7
`define FMS_SUB_LAST 4'hf
`define FMS_LAST_DATA_BIT 3'h7
`endif

// ---- fms_pkg.sv ----
// types shared by the serial port modules
package fms_pkg;
  typedef enum logic [1:0] {
    fms_mode_shift = 2'h0,
    fms_mode_8var = 2'h1,
    fms_mode_9fix = 2'h2,
    fms_mode_9var = 2'h3
  } fms_mode_type;
  typedef enum logic [4:0] {
    fms_tx_idle = 5'h01,
    fms_tx_start = 5'h02,
    fms_tx_data = 5'h04,
    fms_tx_ninth = 5'h08,
    fms_tx_stop = 5'h10
  } fms_tx_state_type;
  typedef enum logic [4:0] {
    fms_rx_idle = 5'h01,
    fms_rx_start = 5'h02,
    fms_rx_data = 5'h04,
    fms_rx_ninth = 5'h08,
    fms_rx_stop = 5'h10
  } fms_rx_state_type;
endpackage

// ---- fms_baud_if.sv ----
// baud generator configuration and sixteen-times tick
`timescale 1ns/1ps
interface fms_baud_if;
  logic [7:0] divisor;
  logic [1:0] clk_sel;
  logic fixed_rate;
  logic tick16;
  modport gen (input divisor, input clk_sel, input fixed_rate, output tick16);
  modport user (output divisor, output clk_sel, output fixed_rate, input tick16);
endinterface

// ---- fms_baud_gen.sv ----
// port clock prescaler and divisor-based sixteen-times bit-rate tick
`timescale 1ns/1ps
`include "fms_defines.svh"
module fms_baud_gen (
  input wire logic clk_i,  // system clock
  input wire logic nrst_i, // async reset, active low
  fms_baud_if.gen bus      // configuration in, tick out
);
  logic [2:0] pre_cnt;
  logic [2:0] pre_mask;
  logic port_tick;
  logic [7:0] div_cnt;
  logic tick;

  // port clock is system clock divided by 1, 2, 4 or 8
  always_comb
  begin
    case (bus.clk_sel)
      2'h0: pre_mask = 3'h0;
      2'h1: pre_mask = 3'h1;
      2'h2: pre_mask = 3'h3;
      default: pre_mask = 3'h7;
    endcase
    port_tick = (pre_cnt & pre_mask) == pre_mask;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pre_cnt <= 3'h0;
    else
      pre_cnt <= pre_cnt + 3'h1;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      div_cnt <= 8'h00;
      tick <= 1'b0;
    end
    else if (port_tick)
    begin
      if (bus.fixed_rate)
      begin
        div_cnt <= 8'h00;
        tick <= 1'b1;
      end
      else if (div_cnt == 8'h00)
      begin
        div_cnt <= bus.divisor;
        tick <= 1'b1;
      end
      else
      begin
        div_cnt <= div_cnt - 8'h01;
        tick <= 1'b0;
      end
    end
    else
      tick <= 1'b0;
  end

  assign bus.tick16 = tick;
endmodule

// ---- fms_remote.sv ----
// remote serial device model on the link pins
`timescale 1ns/1ps
module fms_remote (
  input wire logic clk_i, // system clock
  input wire logic tx_i, // device serial_out_pin
  input wire logic dat_i, // serial_in_pin wire
  output logic line_o // remote drive of serial_in_pin
);
  logic m0;
  logic [7:0] m0_byte;
  int k;
  initial
  begin
    line_o = 1'b1;
    m0 = 1'b0;
    k = 0;
  end
  // shift mode: next bit at each shift clock fall
  always @(negedge tx_i)
  begin
    if (m0)
    begin
      line_o <= m0_byte[k];
      k <= k + 1;
    end
  end
  task automatic send(input logic [8:0] d, input int n, input int bl);
    line_o <= 1'b0;
    repeat (bl) @(posedge clk_i);
    for (int i = 0; i < n; i++)
    begin
      line_o <= d[i];
      repeat (bl) @(posedge clk_i);
    end
    line_o <= 1'b1;
    repeat (bl) @(posedge clk_i);
  endtask
  task automatic recv(output logic [8:0] d, output logic ok, input int n, input int bl);
    int t;
    d = '0;
    t = 0;
    while (tx_i !== 1'b0 && t < 5000)
    begin
      @(posedge clk_i);
      t++;
    end
    repeat (bl / 2) @(posedge clk_i);
    ok = tx_i === 1'b0 && t < 5000;
    for (int i = 0; i < n; i++)
    begin
      repeat (bl) @(posedge clk_i);
      d[i] = tx_i;
    end
    repeat (bl) @(posedge clk_i);
    ok = ok && tx_i === 1'b1;
  endtask
  task automatic m0_recv(output logic [8:0] d, output logic ok);
    int t;
    int i;
    logic p;
    d = '0;
    t = 0;
    i = 0;
    while (i < 8 && t < 5000)
    begin
      p = tx_i;
      @(posedge clk_i);
      t++;
      if (!p && tx_i)
      begin
        d[i] = dat_i;
        i++;
      end
    end
    ok = i == 8;
  endtask
endmodule

// ---- fms_serial_port_checker.sv ----
// assertions on the serial port pins and bus
`timescale 1ns/1ps
`include "fms_defines.svh"
module fms_serial_port_checker (
  input wire logic clk_i, // clock
  input wire logic nrst_i, // reset, active low
  input wire logic psel_i, // select
  input wire logic penable_i, // enable
  input wire logic pwrite_i, // write
  input wire logic [11:0] paddr_i, // address
  input wire logic [31:0] pwdata_i, // write data
  input wire logic [31:0] prdata_o, // read data
  input wire logic pready_o, // ready
  input wire logic pslverr_o, // error
  input wire logic serial_in_i, // data pin in
  input wire logic serial_data_o, // data pin out
  input wire logic serial_data_oe_n_o, // data pin enable
  input wire logic serial_out_o, // tx or shift clock
  input wire logic irq_o // interrupt
);
  localparam logic [11:0] A_CH = {2'b00, `FMS_IDX_CTRL_HIGH, 2'b00};
  localparam logic [11:0] A_CL = {2'b00, `FMS_IDX_CTRL_LOW, 2'b00};
  localparam logic [11:0] A_DT = {2'b00, `FMS_IDX_DATA, 2'b00};
  localparam logic [11:0] A_BR = {2'b00, `FMS_IDX_DIVISOR, 2'b00};
  logic [1:0] md;
  logic rie, tie, dv0, ck0, en, wr, map, fast;
  assign wr = psel_i && penable_i && pwrite_i;
  assign map = paddr_i inside {A_CH, A_CL, A_DT, A_BR};
  assign en = rie || tie;
  assign fast = ck0 && (dv0 || md == 2'h2);
  // shadow of written configuration
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      md <= 2'h0;
      rie <= 1'b0;
      tie <= 1'b0;
      dv0 <= 1'b1;
      ck0 <= 1'b1;
    end
    else if (wr && paddr_i == A_CH)
    begin
      md <= pwdata_i[7:6];
      rie <= pwdata_i[1];
    end
    else if (wr && paddr_i == A_CL)
    begin
      tie <= pwdata_i[1];
      ck0 <= pwdata_i[3:2] == 2'h0;
    end
    else if (wr && paddr_i == A_BR)
      dv0 <= pwdata_i[7:0] == 8'h00;
  end
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_start;
    $fell(serial_out_o) ##1 (!serial_out_o) [*7];
  endsequence
  sequence s_m0bit;
    (!serial_out_o) [*8] ##1 serial_out_o [*8];
  endsequence
  property p_ready;
    psel_i && penable_i |-> pready_o;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_err;
    psel_i && penable_i |-> pslverr_o == !map;
  endproperty
  a_err: assert property (p_err) else $error("error flag wrong");
  property p_unrd;
    psel_i && penable_i && !pwrite_i && !map |-> prdata_o == 32'h0000_0000;
  endproperty
  a_unrd: assert property (p_unrd) else $error("unmapped read not zero");
  property p_txs;
    wr && paddr_i == A_DT && md != 2'h0 && fast && serial_out_o |-> ##[1:3] s_start;
  endproperty
  a_txs: assert property (p_txs) else $error("no start bit");
  property p_oe;
    md != 2'h0 |-> serial_data_oe_n_o;
  endproperty
  a_oe: assert property (p_oe) else $error("data pin driven");
  property p_m0;
    md == 2'h0 && fast && $fell(serial_out_o) |-> s_m0bit;
  endproperty
  a_m0: assert property (p_m0) else $error("shift clock timing");
  property p_ioff;
    wr && !pwdata_i[1] && (paddr_i == A_CH && !tie || paddr_i == A_CL && !rie) |-> ##2 !irq_o;
  endproperty
  a_ioff: assert property (p_ioff) else $error("irq while disabled");
  property p_irise;
    $rose(irq_o) |-> $past(en);
  endproperty
  a_irise: assert property (p_irise) else $error("irq without enable");
endmodule
bind fms_serial_port fms_serial_port_checker u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .serial_in_i(serial_in_i), .serial_data_o(serial_data_o),
  .serial_data_oe_n_o(serial_data_oe_n_o), .serial_out_o(serial_out_o), .irq_o(irq_o));

// ---- fms_serial_port_tb_top.sv ----
// self-checking bench for the serial port
`timescale 1ns/1ps
`include "fms_defines.svh"
module fms_serial_port_tb_top;
  localparam logic [11:0] A_CH = {2'b00, `FMS_IDX_CTRL_HIGH, 2'b00};
  localparam logic [11:0] A_CL = {2'b00, `FMS_IDX_CTRL_LOW, 2'b00};
  localparam logic [11:0] A_DT = {2'b00, `FMS_IDX_DATA, 2'b00};
  localparam logic [11:0] A_BR = {2'b00, `FMS_IDX_DIVISOR, 2'b00};
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, sdat, soe_n, sout, irq, rline, ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [8:0] d, g;
  logic [7:0] ch;
  logic [7:0] exp_q[$];
  int num_errors, cmp_count, bl, n;
  wire sin = soe_n ? rline : sdat;
  always #50 clk = ~clk;
  fms_serial_port dut (.clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .serial_in_i(sin), .serial_data_o(sdat), .serial_data_oe_n_o(soe_n), .serial_out_o(sout), .irq_o(irq));
  fms_remote remote (.clk_i(clk), .tx_i(sout), .dat_i(sin), .line_o(rline));
  task automatic finish_test();
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [8:0] gv, input logic [8:0] ev);
    cmp_count++;
    if (gv !== ev)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, gv, ev);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 8);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 8)
    begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, '0, r);
    chk(r[8:0], {1'b0, e});
  endtask
  task automatic okchk(input logic v);
    chk(9'(v), 9'h001);
    if (v !== 1'b1)
      finish_test();
  endtask
  task automatic wpend(input logic [11:0] a, input int b);
    int t;
    t = 0;
    r = '0;
    while (r[b] !== 1'b1 && t < 300)
    begin
      apb(1'b0, a, '0, r);
      t++;
    end
    okchk(r[b]);
  endtask
  // receive buffer model: newest byte replaces an unread one
  task automatic mrx(input logic [7:0] b);
    if (exp_q.size() > 0)
      exp_q.delete(0);
    exp_q.push_back(b);
  endtask
  task automatic rdat();
    apb(1'b0, A_DT, '0, r);
    chk(r[8:0], {1'b0, exp_q[0]});
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    num_errors++;
    finish_test();
  end
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    void'($urandom(32'h5839));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rchk(A_CH, 8'h00);
    rchk(A_CL, 8'h00);
    apb(1'b1, 12'h3e4, 32'h0000_00ff, r);
    rchk(12'h3e4, 8'h00);
    for (int m = 1; m < 4; m++)
    begin
      bl = (m == 2) ? 16 : 16 * m;
      n = (m == 1) ? 8 : 9;
      d = 9'($urandom());
      if (m == 1)
        d[8] = 1'b0;
      ch = {m[1:0], 2'b01, d[8], 3'b000};
      if (m == 3)
      begin
        ch[3] = ~^d[7:0];
        d[8] = ^d[7:0];
      end
      apb(1'b1, A_BR, 32'(m - 1), r);
      apb(1'b1, A_CL, (m == 3) ? 32'h0000_0082 : 32'h0000_0002, r);
      apb(1'b1, A_CH, {24'h00_0000, ch}, r);
      apb(1'b1, A_DT, {24'h00_0000, d[7:0]}, r);
      remote.recv(g, ok, n, bl);
      okchk(ok);
      chk(g, d);
      rchk(A_CL, (m == 3) ? 8'h83 : 8'h03);
      chk(9'(irq), 9'h001);
      apb(1'b1, A_CL, 32'h0000_0002, r);
      rchk(A_CL, 8'h02);
      chk(9'(irq), 9'h000);
      d = 9'($urandom());
      if (m == 1)
        d[8] = 1'b0;
      apb(1'b1, A_CH, {24'h00_0000, ch | 8'h02}, r);
      remote.send(d, n, bl);
      mrx(d[7:0]);
      apb(1'b0, A_CH, '0, r);
      chk(9'(r[0]), 9'h001);
      if (m > 1)
        chk(9'(r[2]), 9'(d[8]));
      chk(9'(irq), 9'h001);
      rdat();
    end
    apb(1'b1, A_CH, 32'h0000_00d2, r);
    for (int i = 0; i < 2; i++)
    begin
      d = 9'($urandom());
      remote.send(d, n, bl);
      mrx(d[7:0]);
    end
    rdat();
    apb(1'b1, A_CH, 32'h0000_00c0, r);
    remote.send(9'h1a5, n, bl);
    rchk(A_CH, 8'hc0);
    apb(1'b1, A_CH, 32'h0000_00f0, r);
    remote.send(9'h05a, n, bl);
    rchk(A_CH, 8'hf0);
    remote.send(9'h15a, n, bl);
    mrx(8'h5a);
    rchk(A_CH, 8'hf5);
    rdat();
    apb(1'b1, A_BR, '0, r);
    apb(1'b1, A_CH, '0, r);
    apb(1'b1, A_CL, '0, r);
    d = {1'b0, 8'($urandom())};
    apb(1'b1, A_DT, {23'h00_0000, d}, r);
    remote.m0_recv(g, ok);
    okchk(ok);
    chk(g, d);
    wpend(A_CL, 0);
    remote.m0_byte = 8'($urandom());
    remote.k = 0;
    remote.m0 = 1'b1;
    apb(1'b1, A_CH, 32'h0000_0010, r);
    wpend(A_CH, 0);
    mrx(remote.m0_byte);
    rdat();
    finish_test();
  end
endmodule
